// ### rtl/gfd_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef GFD_MAP_SVH
`define GFD_MAP_SVH
`define GFD_ADDR_W          8
`define GFD_DATA_W          8
`define GFD_OFS_MEAS_FULL   8'h05
`define GFD_OFS_SEC_FLAGS   8'h06
`define GFD_OFS_OVR         8'h0A
`define GFD_OFS_RESET       8'h39
`define GFD_RESET_GO        8'h80
`define GFD_LMD_CLEAR       8'h00
`define GFD_BIT_CR          7
`define GFD_BIT_OVERLOAD_FLAG        0
`define GFD_BIT_DR_HI       6
`define GFD_BIT_DR_LO       4
`define GFD_BIT_OCE         0
`define GFD_BIT_OVR_MSB     7
`define GFD_CLK_HZ          50000000
`define GFD_SHOW_MS         4000
`define GFD_SHOW_CYC        ((`GFD_CLK_HZ / 1000) * `GFD_SHOW_MS)
`define GFD_PULSE_MS        25
`define GFD_PULSE_CYC       ((`GFD_CLK_HZ / 1000) * `GFD_PULSE_MS)
`define GFD_MUX_HZ          320
`define GFD_MUX_CYC         (`GFD_CLK_HZ / `GFD_MUX_HZ)
`define GFD_MUX_ON_PCT      30
`define GFD_MUX_ON_CYC      ((`GFD_MUX_CYC * `GFD_MUX_ON_PCT) / 100)
`define GFD_BLINK_HZ        4
`define GFD_BLINK_HALF_CYC  (`GFD_CLK_HZ / (2 * `GFD_BLINK_HZ))
`define GFD_CR_MIN_CPS      2
`define GFD_CR_WIN_CYC      `GFD_CLK_HZ
`define GFD_SENSE_10MV      16'd10000
`define GFD_SENSE_20MV      16'd20000
`define GFD_SENSE_40MV      16'd40000
`define GFD_SENSE_60MV      16'd60000
`define GFD_SENSE_2MV       16'd2000
`define GFD_LOW_PCT         10
`endif

// ### rtl/gfd_pkg.sv
// Types shared by both ends of the gauge link
package gfd_pkg;
  typedef logic [7:0] gfd_byte_t;
  typedef enum logic [2:0]
  {
    GFD_H_IDLE  = 3'b001,
    GFD_H_CLEAR = 3'b010,
    GFD_H_KICK  = 3'b100
  } gfd_hstate_e;
endpackage

// ### rtl/gfd_link_if.sv
// Register link between host and gauge
`timescale 1ns/10ps
interface gfd_link_if;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic       wr;
  logic       rd;
  logic [7:0] rdata;
  modport dev
  (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    output rdata
  );
  modport host
  (
    output addr,
    output wdata,
    output wr,
    output rd,
    input  rdata
  );
endinterface

// ### rtl/gfd_seg_mux.sv
// Two-bank segment modulator with low-battery blink
`timescale 1ns/10ps
`include "gfd_map.svh"
module gfd_seg_mux
  import gfd_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic [4:0] bar_in,
  input  wire logic       blink_in,
  output logic      [4:0] seg_out,
  output logic            com_out
);
  logic [17:0] mux_cnt_q;
  logic [22:0] blink_cnt_q;
  logic        blink_ph_q;
  wire         mux_wrap = mux_cnt_q == 18'(`GFD_MUX_CYC - 1);
  wire         half     = mux_cnt_q >= 18'(`GFD_MUX_CYC / 2);
  wire         bank_on  = mux_cnt_q < 18'(`GFD_MUX_ON_CYC)
                       || (half && (mux_cnt_q - 18'(`GFD_MUX_CYC / 2))
                           < 18'(`GFD_MUX_ON_CYC));
  wire  [4:0]  bar_b    = {bar_in[4:1], bar_in[0] & ~(blink_in & blink_ph_q)};
  wire  [4:0]  bank_a   = bar_b & 5'h15;
  wire  [4:0]  bank_b   = bar_b & 5'h0A;
  wire  [4:0]  seg_d    = bank_on ? (half ? bank_b : bank_a) : 5'h00;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      mux_cnt_q   <= 18'h0;
      blink_cnt_q <= 23'h0;
      blink_ph_q  <= 1'b0;
      seg_out     <= 5'h00;
      com_out     <= 1'b0;
    end
    else
    begin
      mux_cnt_q   <= mux_wrap ? 18'h0 : mux_cnt_q + 18'h1;
      blink_cnt_q <= (blink_cnt_q == 23'(`GFD_BLINK_HALF_CYC - 1)) ? 23'h0
                     : blink_cnt_q + 23'h1;
      if (blink_cnt_q == 23'(`GFD_BLINK_HALF_CYC - 1))
        blink_ph_q <= ~blink_ph_q;
      seg_out     <= seg_d;
      com_out     <= |seg_d;
    end
endmodule

// ### rtl/gfd_gauge.sv
// Gauge end: secondary flags, segment override, reset, LED display
//
// Functional notes
// - Read-only secondary flags at 06h
// - Charge start sets charge-rate flag
// - Charge-rate flag holds at >=2 counts/s
// - Charge-rate flag exported for fast/trickle efficiency select
// - Discharge band in bits 6-4
// - Overload flag bit 0 above 60 mV
// - Write-only override register 0Ah, bit0 enable
// - Override bits 5-1 drive segments 5-1
// - Host sets MSB on every override write
// - Override enable cleared by write or reset
// - Host clears 05h, then writes 80h to 39h
// - Host sets only reset register MSB
// - Reset loads full count, clears valid-discharge flag, sets replaced
// - Each segment is 20% of full count
// - Temperature scales display, not stored count
// - Show pin high off; floating shows on activity
// - Floating also shows after 20mV 25ms pulse
// - Show pin low lights segments 4 seconds
// - Two banks at 320Hz, 30% each
// - Segment one blinks 4Hz when low
// - Overload suppresses end-of-discharge detection
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "gfd_map.svh"
module gfd_gauge
  import gfd_pkg::*;
(
  input  wire logic        mclk_in,
  input  wire logic        rst_b_in,
  gfd_link_if.dev          link,
  input  wire logic [15:0] sense_uv_in,
  input  wire logic        charging_in,
  input  wire logic        charge_count_in,
  input  wire logic        vsb_low_in,
  input  wire logic [7:0]  programmed_full_in,
  input  wire logic [7:0]  avail_in,
  input  wire logic        avail_load_in,
  input  wire logic [1:0]  temp_band_in,
  input  wire logic        show_low_in,
  input  wire logic        show_float_in,
  input  wire logic        capacity_select_pin_four_low_in,
  output logic      [4:0]  led_bar_outputs_out,
  output logic             led_common_output_out,
  output logic             charge_rate_flag_out,
  output logic             end_of_discharge_flag_out,
  output logic      [7:0]  measured_full_out,
  output logic      [7:0]  available_charge_out,
  output logic             valid_discharge_flag_out,
  output logic             battery_replaced_flag_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] low_s_q;
  logic [1:0] flt_s_q;
  logic [1:0] p4_s_q;
  logic [1:0] vsb_s_q;
  wire        show_low = low_s_q[1];
  wire        show_flt = flt_s_q[1];
  logic        cr_q;
  logic        chg_prev_q;
  logic [25:0] cr_win_q;
  logic [1:0]  cr_cnt_q;
  logic        ovr_en_q;
  logic [4:0]  ovr_bits_q;
  logic [7:0]  lmd_q;
  logic [7:0]  nac_q;
  logic        vdq_q;
  logic        brp_q;
  logic        edv_q;
  logic        soft_rst_q;
  logic        rst_seen_q;
  logic        lmd_cleared_q;
  logic [7:0]  rdata_q;
  logic [27:0] show_cnt_q;
  logic [20:0] pulse_cnt_q;
  logic [4:0]  bar_q;
  logic        blink_q;
  logic [4:0]  mux_seg;
  logic        mux_com;
  ////////////////////////////////////////////////////////////////////////////
  // Decode and combinational values
  function automatic logic [2:0] dr_band(input logic [15:0] uv);
    if (uv > `GFD_SENSE_60MV)      dr_band = 3'h4;
    else if (uv > `GFD_SENSE_40MV) dr_band = 3'h3;
    else if (uv > `GFD_SENSE_20MV) dr_band = 3'h2;
    else if (uv > `GFD_SENSE_10MV) dr_band = 3'h1;
    else                           dr_band = 3'h0;
  endfunction
  wire        overload_flag      = !charging_in && sense_uv_in > `GFD_SENSE_60MV;
  wire  [2:0] band      = charging_in ? 3'h0 : dr_band(sense_uv_in);
  wire  [7:0] flags2    = {cr_q, band, 3'h0, overload_flag};
  wire        wr_lmd    = link.wr && link.addr == `GFD_OFS_MEAS_FULL;
  wire        wr_ovr    = link.wr && link.addr == `GFD_OFS_OVR;
  wire        wr_rst    = link.wr && link.addr == `GFD_OFS_RESET;
  wire        rst_go    = wr_rst && link.wdata == `GFD_RESET_GO
                          && !rst_seen_q && lmd_cleared_q;
  wire        chg_start = charging_in && !chg_prev_q;
  wire        cr_wrap   = cr_win_q == 26'(`GFD_CR_WIN_CYC - 1);
  // Temperature scaling on a copy only; stored count untouched
  wire  [9:0] adj_nac   = (temp_band_in == 2'h0) ? {nac_q, 2'h0}
                          : (temp_band_in == 2'h1) ? ({2'h0, nac_q} * 10'd3)
                          : {1'b0, nac_q, 1'b0};
  wire [12:0] fifth     = {5'h00, programmed_full_in};
  wire [12:0] adj5      = {3'h0, adj_nac} * 13'd5;
  wire  [2:0] segs      = (adj5 >= fifth * 13'd20) ? 3'd5
                        : (adj5 >= fifth * 13'd16) ? 3'd4
                        : (adj5 >= fifth * 13'd12) ? 3'd3
                        : (adj5 >= fifth * 13'd8)  ? 3'd2
                        : (adj5 >= fifth * 13'd4)  ? 3'd1
                        : 3'd0;
  wire  [4:0] bar_lvl   = 5'((6'h01 << segs) - 6'h01);
  wire        active    = !charging_in ? sense_uv_in > `GFD_SENSE_2MV
                                       : charge_count_in;
  wire        show_on   = show_cnt_q != 28'h0
                          || (show_flt && (active || pulse_cnt_q == 21'(
                              `GFD_PULSE_CYC)));
  wire        low_bat   = edv_q || (16'(nac_q) * 16'd100
                          < 16'(programmed_full_in) * 16'(`GFD_LOW_PCT));
  wire  [4:0] bar_d     = ovr_en_q ? ovr_bits_q
                          : (show_on ? bar_lvl : 5'h00);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      low_s_q <= 2'h0;
      flt_s_q <= 2'h0;
      p4_s_q  <= 2'h0;
      vsb_s_q <= 2'h0;
    end
    else
    begin
      low_s_q <= {low_s_q[0], show_low_in};
      flt_s_q <= {flt_s_q[0], show_float_in};
      p4_s_q  <= {p4_s_q[0], capacity_select_pin_four_low_in};
      vsb_s_q <= {vsb_s_q[0], vsb_low_in};
    end
  // Charge-rate flag: one-second window counts charge ticks
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      cr_q       <= 1'b0;
      chg_prev_q <= 1'b0;
      cr_win_q   <= 26'h0;
      cr_cnt_q   <= 2'h0;
    end
    else
    begin
      chg_prev_q <= charging_in;
      cr_win_q   <= (cr_wrap || chg_start) ? 26'h0 : cr_win_q + 26'h1;
      if (chg_start || cr_wrap)
        cr_cnt_q <= 2'h0;
      else if (charge_count_in && cr_cnt_q != 2'h3)
        cr_cnt_q <= cr_cnt_q + 2'h1;
      if (chg_start)
        cr_q <= 1'b1;
      else if (!charging_in || (cr_wrap && cr_cnt_q < 2'(`GFD_CR_MIN_CPS)))
        cr_q <= 1'b0;
    end
  // Registers, software reset
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      ovr_en_q      <= 1'b0;
      ovr_bits_q    <= 5'h00;
      lmd_q         <= 8'h00;
      nac_q         <= 8'h00;
      vdq_q         <= 1'b0;
      brp_q         <= 1'b1;
      edv_q         <= 1'b0;
      soft_rst_q    <= 1'b1;
      rst_seen_q    <= 1'b0;
      lmd_cleared_q <= 1'b0;
      rdata_q       <= 8'h00;
    end
    else
    begin
      rdata_q    <= (link.rd && link.addr == `GFD_OFS_SEC_FLAGS) ? flags2
                    : 8'h00;
      soft_rst_q <= rst_go;
      if (wr_rst)
        rst_seen_q <= link.wdata[`GFD_BIT_OVR_MSB];
      if (wr_lmd)
        lmd_cleared_q <= link.wdata == `GFD_LMD_CLEAR;
      if (soft_rst_q)
      begin
        lmd_q    <= programmed_full_in;
        nac_q    <= p4_s_q[1] ? programmed_full_in : 8'h00;
        vdq_q    <= 1'b0;
        ovr_en_q <= 1'b0;
        brp_q    <= 1'b1;
        lmd_cleared_q <= 1'b0;
      end
      else
      begin
        if (wr_ovr)
        begin
          ovr_en_q   <= link.wdata[`GFD_BIT_OCE];
          ovr_bits_q <= link.wdata[5:1];
        end
        if (wr_lmd)
          lmd_q <= link.wdata;
        if (avail_load_in)
          nac_q <= avail_in;
        if (avail_load_in && !charging_in && nac_q == lmd_q)
          vdq_q <= 1'b1;
        if ((avail_load_in && charging_in && avail_in == lmd_q)
            || (vsb_s_q[1] && !overload_flag && !edv_q))
          brp_q <= 1'b0;
      end
      if (charging_in && charge_count_in)
        edv_q <= 1'b0;
      else if (vsb_s_q[1] && !overload_flag)
        edv_q <= 1'b1;
    end
  // Display timers
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      show_cnt_q  <= 28'h0;
      pulse_cnt_q <= 21'h0;
      bar_q       <= 5'h00;
      blink_q     <= 1'b0;
    end
    else
    begin
      if (show_low && show_cnt_q == 28'h0)
        show_cnt_q <= 28'(`GFD_SHOW_CYC);
      else if (show_cnt_q != 28'h0 && !show_low)
        show_cnt_q <= show_cnt_q - 28'h1;
      if (charging_in || sense_uv_in <= `GFD_SENSE_20MV)
        pulse_cnt_q <= 21'h0;
      else if (pulse_cnt_q != 21'(`GFD_PULSE_CYC))
        pulse_cnt_q <= pulse_cnt_q + 21'h1;
      bar_q   <= show_flt || show_low || show_cnt_q != 28'h0 || ovr_en_q
                 ? bar_d : 5'h00;
      blink_q <= low_bat && !ovr_en_q;
    end
  assign link.rdata = rdata_q;
  ////////////////////////////////////////////////////////////////////////////
  // Efficiency select lives outside; flag exported for it
  gfd_seg_mux u_mux
  (
    .mclk_in  (mclk_in),
    .rst_b_in (rst_b_in),
    .bar_in   (bar_q),
    .blink_in (blink_q),
    .seg_out  (mux_seg),
    .com_out  (mux_com)
  );
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      charge_rate_flag_out      <= 1'b0;
      end_of_discharge_flag_out <= 1'b0;
      measured_full_out         <= 8'h00;
      available_charge_out      <= 8'h00;
      valid_discharge_flag_out  <= 1'b0;
      battery_replaced_flag_out <= 1'b1;
      led_bar_outputs_out       <= 5'h00;
      led_common_output_out     <= 1'b0;
    end
    else
    begin
      charge_rate_flag_out      <= cr_q;
      end_of_discharge_flag_out <= edv_q;
      measured_full_out         <= lmd_q;
      available_charge_out      <= nac_q;
      valid_discharge_flag_out  <= vdq_q;
      battery_replaced_flag_out <= brp_q;
      led_bar_outputs_out       <= ovr_en_q ? ovr_bits_q : mux_seg;
      led_common_output_out     <= ovr_en_q ? |ovr_bits_q : mux_com;
    end
endmodule

// ### rtl/gfd_host.sv
// Host end: passes register accesses, runs the software reset sequence
`timescale 1ns/10ps
`include "gfd_map.svh"
module gfd_host
  import gfd_pkg::*;
(
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  gfd_link_if.host        link,
  input  wire logic [7:0] addr_in,
  input  wire logic [7:0] wdata_in,
  input  wire logic       wr_in,
  input  wire logic       rd_in,
  input  wire logic       reset_req_in,
  output logic      [7:0] rdata_out,
  output logic            busy_out
);
  gfd_hstate_e state_q;
  logic [7:0]  addr_q;
  logic [7:0]  wdata_q;
  logic        wr_q;
  logic        rd_q;
  // Override writes always carry MSB set
  wire  [7:0]  wd_fix = (addr_in == `GFD_OFS_OVR)
                        ? (wdata_in | 8'h80) : wdata_in;
  // Reset register only ever gets MSB
  wire  [7:0]  wd_use = (addr_in == `GFD_OFS_RESET)
                        ? (wdata_in & 8'h80) : wd_fix;
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_in or negedge rst_b_in)
    if (!rst_b_in)
    begin
      state_q   <= GFD_H_IDLE;
      addr_q    <= 8'h00;
      wdata_q   <= 8'h00;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      rdata_out <= 8'h00;
      busy_out  <= 1'b0;
    end
    else
    begin
      rdata_out <= link.rdata;
      wr_q      <= 1'b0;
      rd_q      <= 1'b0;
      case (state_q)
        GFD_H_IDLE:
          if (reset_req_in)
          begin
            addr_q   <= `GFD_OFS_RESET;
            wdata_q  <= 8'h00;
            wr_q     <= 1'b1;
            busy_out <= 1'b1;
            state_q  <= GFD_H_CLEAR;
          end
          else
          begin
            addr_q  <= addr_in;
            wdata_q <= wd_use;
            wr_q    <= wr_in;
            rd_q    <= rd_in & ~wr_in;
          end
        GFD_H_CLEAR:
        begin
          addr_q  <= `GFD_OFS_MEAS_FULL;
          wdata_q <= `GFD_LMD_CLEAR;
          wr_q    <= 1'b1;
          state_q <= GFD_H_KICK;
        end
        GFD_H_KICK:
        begin
          addr_q   <= `GFD_OFS_RESET;
          wdata_q  <= `GFD_RESET_GO;
          wr_q     <= 1'b1;
          busy_out <= 1'b0;
          state_q  <= GFD_H_IDLE;
        end
        default:
          state_q <= GFD_H_IDLE;
      endcase
    end
  assign link.addr  = addr_q;
  assign link.wdata = wdata_q;
  assign link.wr    = wr_q;
  assign link.rd    = rd_q;
endmodule

// ### testbench/gfd_link_asserts.sv
// Concurrent checks on the host-to-gauge register link
`timescale 1ns/10ps
`include "gfd_map.svh"
module gfd_link_asserts
(
  input  wire logic       mclk_in,
  input  wire logic       rst_b_in,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  input  wire logic [7:0] rdata
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_flags_read;
    $past(rd) && ($past(addr) == `GFD_OFS_SEC_FLAGS);
  endsequence
  sequence s_zero_reset;
    wr && (addr == `GFD_OFS_RESET) && (wdata == 8'h00);
  endsequence
  sequence s_clear_full;
    wr && (addr == `GFD_OFS_MEAS_FULL) && (wdata == `GFD_LMD_CLEAR);
  endsequence
  sequence s_kick;
    wr && (addr == `GFD_OFS_RESET) && (wdata == `GFD_RESET_GO);
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_rdata_idle_zero: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  a_other_reads_zero: assert property (($past(rd) &&
    ($past(addr) != `GFD_OFS_SEC_FLAGS)) |-> rdata == 8'h00)
    else $error("read of unmapped address returned data");
  a_band_code_legal: assert property
    (s_flags_read |-> rdata[6:4] <= 3'h4)
    else $error("discharge band code out of range");
  a_overload_tracks_band: assert property
    (s_flags_read |-> rdata[0] == (rdata[6:4] == 3'h4))
    else $error("overload flag disagrees with band code");
  a_strobes_exclusive: assert property (!(wr && rd))
    else $error("write and read strobes together");
  a_override_msb_set: assert property
    ((wr && addr == `GFD_OFS_OVR) |-> wdata[7])
    else $error("override write without top bit set");
  a_reset_msb_only: assert property
    ((wr && addr == `GFD_OFS_RESET) |-> wdata[6:0] == 7'h00)
    else $error("reset register write sets low bits");
  a_kick_after_clear: assert property
    (s_kick |-> $past(wr && addr == `GFD_OFS_MEAS_FULL && wdata == 8'h00))
    else $error("reset kick not preceded by full count clear");
  a_clear_then_kick: assert property
    (s_zero_reset ##1 s_clear_full |=> s_kick)
    else $error("reset sequence broken after clear");
  c_soft_reset: cover property (s_zero_reset ##1 s_clear_full ##1 s_kick);
endmodule

// ### testbench/gfd_tb_top.sv
// Self-checking bench joining the gauge and host ends over the link
`timescale 1ns/10ps
module gfd_tb_top;
  logic        mclk_in = 1'b0;
  logic        rst_b_in = 1'b0;
  logic [7:0]  addr_in = 8'h00;
  logic [7:0]  wdata_in = 8'h00;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic        reset_req_in = 1'b0;
  logic [15:0] sense_uv_in = 16'h0000;
  logic        charging_in = 1'b0;
  logic        count_in = 1'b0;
  logic        vsb_low_in = 1'b0;
  logic [7:0]  pfc_in = 8'h00;
  logic [7:0]  avail_in = 8'h00;
  logic        load_in = 1'b0;
  logic [1:0]  temp_in = 2'h0;
  logic        capacity_select_pin_four_in = 1'b0;
  logic        show_low_in = 1'b0;
  logic        show_float_in = 1'b0;
  logic [7:0]  rdata_out, meas_full, avail_out, rd_val, pf, av;
  logic [4:0]  led_bar, seg;
  logic        busy_out, led_com, cr_flag, eod_flag, vdq_flag, brp_flag;
  logic [15:0] uv;
  logic [15:0] corner [4] = '{16'h2710, 16'h2711, 16'hEA60, 16'hEA61};
  logic [31:0] lfsr_q = 32'd85122;
  int          miscompares = 0;
  int          comparisons = 0;
  int          cyc = 0;
  int          n;
  ////////////////////////////////////////////////////////////////////////////
  gfd_link_if gfd_link_if_inst ();
  gfd_host gfd_host_inst
  (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .link(gfd_link_if_inst),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .reset_req_in(reset_req_in), .rdata_out(rdata_out), .busy_out(busy_out)
  );
  gfd_gauge gfd_gauge_inst
  (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in), .link(gfd_link_if_inst),
    .sense_uv_in(sense_uv_in), .charging_in(charging_in),
    .charge_count_in(count_in), .vsb_low_in(vsb_low_in),
    .programmed_full_in(pfc_in), .avail_in(avail_in),
    .avail_load_in(load_in), .temp_band_in(temp_in),
    .show_low_in(show_low_in), .show_float_in(show_float_in),
    .capacity_select_pin_four_low_in(capacity_select_pin_four_in),
    .led_bar_outputs_out(led_bar), .led_common_output_out(led_com),
    .charge_rate_flag_out(cr_flag), .end_of_discharge_flag_out(eod_flag),
    .measured_full_out(meas_full), .available_charge_out(avail_out),
    .valid_discharge_flag_out(vdq_flag),
    .battery_replaced_flag_out(brp_flag)
  );
  gfd_link_asserts gfd_link_asserts_inst
  (
    .mclk_in(mclk_in), .rst_b_in(rst_b_in),
    .addr(gfd_link_if_inst.addr), .wdata(gfd_link_if_inst.wdata),
    .wr(gfd_link_if_inst.wr), .rd(gfd_link_if_inst.rd),
    .rdata(gfd_link_if_inst.rdata)
  );
  ////////////////////////////////////////////////////////////////////////////
  always #10 mclk_in = ~mclk_in;
  // Whole run is a few hundred cycles; this only catches a hang
  always @(posedge mclk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 8000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] flags_exp(input logic [15:0] u);
    logic [2:0] b;
    b = (u <= 16'h2710) ? 3'h0 : (u <= 16'h4E20) ? 3'h1 :
        (u <= 16'h9C40) ? 3'h2 : (u <= 16'hEA60) ? 3'h3 : 3'h4;
    return {1'b0, b, 3'h0, b == 3'h4};
  endfunction
  // Lit count is adjusted charge over a fifth of full; bank A is 1, 3, 5
  function automatic logic [7:0] bar_exp(input logic [7:0] c,
                                          input logic [1:0] t,
                                          input logic [7:0] f);
    int k;
    k = (int'(c) * ((t == 2'h0) ? 20 : (t == 2'h1) ? 15 : 10))
        / (int'(f) * 4);
    if (k > 5)
      k = 5;
    return 8'((1 << k) - 1) & 8'h15;
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge mclk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask
  // Answer reaches the user port two edges after the link strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    tick(2);
    d = rdata_out;
  endtask
  task automatic print_verdict();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (16) @(posedge mclk_in);
    rst_b_in <= 1'b1;
    tick(2);
    check({vdq_flag, brp_flag, cr_flag, eod_flag}, 8'h04);
    check(led_bar, 8'h00);
    $display("test pin reset done");
    for (int i = 0; i < 12; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      uv = (i < 4) ? corner[i] : lfsr_q[15:0];
      @(posedge mclk_in);
      sense_uv_in <= uv;
      tick(4);
      if (i % 2 == 1)
        wr_reg(8'h06, ~flags_exp(uv));
      rd_reg(8'h06, rd_val);
      check(rd_val, flags_exp(uv));
    end
    $display("test flags done");
    @(posedge mclk_in);
    sense_uv_in <= 16'h0000;
    charging_in <= 1'b1;
    count_in <= 1'b1;
    @(posedge mclk_in);
    count_in <= 1'b0;
    tick(6);
    check(cr_flag, 8'h01);
    rd_reg(8'h06, rd_val);
    check(rd_val[7], 8'h01);
    @(posedge mclk_in);
    charging_in <= 1'b0;
    tick(6);
    check(cr_flag, 8'h00);
    $display("test charge rate done");
    @(posedge mclk_in);
    sense_uv_in <= 16'hEA61;
    vsb_low_in <= 1'b1;
    tick(8);
    check(eod_flag, 8'h00);
    @(posedge mclk_in);
    sense_uv_in <= 16'h0000;
    tick(8);
    check(eod_flag, 8'h01);
    $display("test empty detect done");
    for (int i = 0; i < 4; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      seg = (i == 0) ? 5'h1F : lfsr_q[4:0];
      wr_reg(8'h0A, {2'h2, seg, 1'b1});
      tick(4);
      check(led_bar, seg);
      wr_reg(8'h0A, {2'h2, seg, 1'b0});
      tick(4);
      check(led_bar, 8'h00);
    end
    $display("test override done");
    av = lfsr_q[15:8];
    @(posedge mclk_in);
    avail_in <= av;
    load_in <= 1'b1;
    @(posedge mclk_in);
    load_in <= 1'b0;
    for (int t = 0; t < 4; t++)
    begin
      @(posedge mclk_in);
      temp_in <= t[1:0];
      tick(3);
      check(avail_out, av);
    end
    $display("test temperature done");
    for (int p = 0; p < 2; p++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      pf = lfsr_q[7:0];
      wr_reg(8'h0A, 8'h83);
      @(posedge mclk_in);
      pfc_in <= pf;
      capacity_select_pin_four_in <= p[0];
      reset_req_in <= 1'b1;
      @(posedge mclk_in);
      reset_req_in <= 1'b0;
      tick(1);
      n = 0;
      while (busy_out !== 1'b0 && n < 50)
      begin
        tick(1);
        n++;
      end
      tick(8);
      check(meas_full, pf);
      check(avail_out, (p == 1) ? pf : 8'h00);
      check({vdq_flag, brp_flag}, 8'h01);
      check(led_bar, 8'h00);
    end
    $display("test soft reset done");
    @(posedge mclk_in);
    pfc_in <= 8'h64;
    sense_uv_in <= 16'h0BB8;
    show_float_in <= 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      av = (i == 0) ? 8'h00 : {1'b0, lfsr_q[6:0]};
      @(posedge mclk_in);
      avail_in <= av;
      load_in <= 1'b1;
      temp_in <= lfsr_q[9:8];
      @(posedge mclk_in);
      load_in <= 1'b0;
      tick(6);
      // Run is short, so the modulator is still in its bank A slot
      check(led_bar, bar_exp(av, temp_in, 8'h64));
      check(led_com, |bar_exp(av, temp_in, 8'h64));
    end
    $display("test display float done");
    @(posedge mclk_in);
    show_float_in <= 1'b0;
    tick(8);
    check(led_bar, 8'h00);
    @(posedge mclk_in);
    show_low_in <= 1'b1;
    tick(8);
    check(led_bar, bar_exp(av, temp_in, 8'h64));
    $display("test display pin low done");
    print_verdict();
  end
endmodule
